// ### tsv_pkg.sv
// Constants and types shared by the transfer status validation block
package tsv_pkg;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_SOURCE = 8'h14;
    localparam logic [7:0] ADDR_DEST = 8'h18;
    localparam logic [7:0] ADDR_TYPE = 8'h1c;
    localparam logic [7:0] ADDR_TXDATA = 8'h20;
    localparam logic [7:0] ADDR_RXDATA = 8'h24;

    // Field positions
    localparam int CTRL_TX_BIT = 11;
    localparam int CTRL_RX_BIT = 12;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TX_DONE_BIT = 6;
    localparam int STAT_TX_ERR_BIT = 7;
    localparam int STAT_RX_DONE_BIT = 8;
    localparam int TYPE_PARAM_BIT = 0;
    localparam int POS_SIGN_BIT = 15;

    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] DESC_RESET = 16'h0000;

    // Transfer limits
    localparam logic [13:0] COUNT_MIN = 14'h0003;
    localparam logic [13:0] COUNT_MAX = 14'h1770;
    localparam logic [1:0] POS_BLOCK = 2'h3;
    localparam logic [1:0] PAR_BLOCK = 2'h2;
    localparam logic [14:0] HOST_MEM_TOP = 15'h19ff;
    localparam int MEM_AW = 10;
    localparam logic [14:0] MEM_DEPTH = 15'h0400;

    // Position value format
    localparam logic [3:0] POS_TOP_DIGIT_MAX = 4'h3;
    localparam logic [3:0] POS_POINT_MAX = 4'h4;

    // Upper bound of each parameter value, chosen by parameter number
    localparam logic [13:0] PARAM_LIMIT_0 = 14'h270f;
    localparam logic [13:0] PARAM_LIMIT_1 = 14'h03e7;
    localparam logic [13:0] PARAM_LIMIT_2 = 14'h0063;
    localparam logic [13:0] PARAM_LIMIT_3 = 14'h0001;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TX_DATA,
        ST_COMMIT,
        ST_RX_DATA
    } tsv_state_t;

endpackage : tsv_pkg

// ### tsv_mem.sv
// Internal data memory with registered read port
`timescale 1ns/100ps
`default_nettype none
module tsv_mem
    import tsv_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic we,
    input wire logic [MEM_AW-1:0] waddr,
    input wire logic [15:0] wdata,
    // Read port
    input wire logic [MEM_AW-1:0] raddr,
    output logic [15:0] rdata
);

    logic [15:0] store [0:(1<<MEM_AW)-1];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= store[raddr];
    end

endmodule : tsv_mem
`default_nettype wire

// ### tsv_transfer_status.sv
// Transfer validation, completion handshakes and AXI4-Lite registers
//
// What this block does
// - Error if count, source or destination not BCD
// - Error if source beyond host memory top
// - Error if destination outside accepted range
// - Error unless count 3..6000 in whole blocks
// - Error if source plus count passes top plus one
// - Error if position value has non-BCD digit
// - Error if decimal point place not allowed
// - Error if position beyond plus/minus 39,999,999
// - Error if parameter value not BCD
// - Error if parameter value outside its range
// - Clean transmission clears the error flag
// - Reception end always sets reception completion
// - Reception completion held until control bit cleared
// - No new reception while completion flag set
// - Transmission completion set, held, blocks new transmissions
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module tsv_transfer_status
    import tsv_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    function automatic logic bcd_ok(input logic [15:0] b);
        bcd_ok = (b[15:12] <= 4'h9) && (b[11:8] <= 4'h9) && (b[7:4] <= 4'h9)
            && (b[3:0] <= 4'h9);
    endfunction : bcd_ok

    function automatic logic [13:0] bcd2bin(input logic [15:0] b);
        bcd2bin = 14'(b[15:12]) * 14'h03e8 + 14'(b[11:8]) * 14'h0064
            + 14'(b[7:4]) * 14'h000a + 14'(b[3:0]);
    endfunction : bcd2bin

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge

    // Register state
    logic [15:0] ctrl;
    logic [15:0] cnt_word;
    logic [15:0] src_word;
    logic [15:0] dst_word;
    logic [15:0] type_word;
    logic tx_done;
    logic tx_err;
    logic rx_done;
    tsv_state_t state;

    // Bus state
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] ar_addr;
    logic rd_pend;

    // Transfer state
    logic [15:0] blk [0:2];
    logic [1:0] widx;
    logic [1:0] ci;
    logic [13:0] left;
    logic [MEM_AW-1:0] dst_ptr;
    logic [MEM_AW-1:0] rx_ptr;
    logic [15:0] mem_q;

    // Descriptor decode
    wire is_param = type_word[TYPE_PARAM_BIT];
    wire [1:0] blk_len = is_param ? PAR_BLOCK : POS_BLOCK;
    wire [13:0] cnt_bin = bcd2bin(cnt_word);
    wire [13:0] src_bin = bcd2bin(src_word);
    wire [13:0] dst_bin = bcd2bin(dst_word);
    wire [14:0] src_end = 15'(src_bin) + 15'(cnt_bin);
    wire [14:0] dst_end = 15'(dst_bin) + 15'(cnt_bin);
    wire desc_bcd_bad = !bcd_ok(cnt_word) || !bcd_ok(src_word)
        || !bcd_ok(dst_word);
    wire src_bad = 15'(src_bin) > HOST_MEM_TOP;
    wire dst_bad = dst_end > MEM_DEPTH;
    wire cnt_range_bad = (cnt_bin < COUNT_MIN) || (cnt_bin > COUNT_MAX);
    wire cnt_mult_bad = is_param ? (cnt_bin[0] != 1'b0)
        : ((cnt_bin % 14'h0003) != 14'h0000);
    wire span_bad = src_end > (HOST_MEM_TOP + 15'h0001);
    wire desc_bad = desc_bcd_bad || src_bad || dst_bad || cnt_range_bad
        || cnt_mult_bad || span_bad;

    // Block checks, last word taken straight from the bus
    wire [15:0] last_word = w_data[15:0];
    wire [15:0] pos_lo = blk[0];
    wire [15:0] pos_hi = blk[1];
    wire pos_bcd_bad = !bcd_ok(pos_lo) || !bcd_ok(pos_hi);
    wire pos_point_bad = (last_word[3:0] > POS_POINT_MAX)
        || (last_word[14:4] != 11'h000);
    wire pos_range_bad = pos_hi[15:12] > POS_TOP_DIGIT_MAX;
    wire [13:0] par_num = bcd2bin(blk[0]);
    wire [13:0] par_val = bcd2bin(last_word);
    wire [13:0] par_limit = (par_num[1:0] == 2'h0) ? PARAM_LIMIT_0
        : (par_num[1:0] == 2'h1) ? PARAM_LIMIT_1
        : (par_num[1:0] == 2'h2) ? PARAM_LIMIT_2 : PARAM_LIMIT_3;
    wire par_bcd_bad = !bcd_ok(blk[0]) || !bcd_ok(last_word);
    wire par_range_bad = par_val > par_limit;
    wire blk_bad = is_param ? (par_bcd_bad || par_range_bad)
        : (pos_bcd_bad || pos_point_bad || pos_range_bad);

    // Bus decode
    wire aw_taken = s_axi_awvalid && s_axi_awready;
    wire w_taken = s_axi_wvalid && s_axi_wready;
    wire ar_taken = s_axi_arvalid && s_axi_arready;
    wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid
        && (state != ST_COMMIT);
    wire wr_ctrl = do_write && (aw_addr == ADDR_CTRL);
    wire wr_desc_ok = do_write && (state == ST_IDLE);
    wire wr_push = do_write && (aw_addr == ADDR_TXDATA) && (state == ST_TX_DATA);
    wire wr_mapped = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_COUNT)
        || (aw_addr == ADDR_SOURCE) || (aw_addr == ADDR_DEST)
        || (aw_addr == ADDR_TYPE) || (aw_addr == ADDR_TXDATA);
    wire rd_pop = ar_taken && (s_axi_araddr == ADDR_RXDATA)
        && (state == ST_RX_DATA);

    // Start conditions
    wire tx_req = ctrl[CTRL_TX_BIT] && !tx_done && (state == ST_IDLE);
    wire rx_req = ctrl[CTRL_RX_BIT] && !rx_done && (state == ST_IDLE)
        && !tx_req;
    wire blk_end = wr_push && (widx == blk_len - 2'h1);
    wire commit_end = (state == ST_COMMIT) && (ci == blk_len - 2'h1);
    wire tx_fin = (tx_req && desc_bad) || (blk_end && blk_bad)
        || (commit_end && (left == 14'h0000));
    wire tx_fin_err = (tx_req && desc_bad) || (blk_end && blk_bad);
    wire rx_fin = (rx_req && (desc_bcd_bad || dst_bad || cnt_bin == 14'h0000))
        || (rd_pop && (left == 14'h0001));

    // Status word
    wire [15:0] status_word = {7'h00, rx_done, tx_err, tx_done, 5'h00,
        state != ST_IDLE};

    // Read selection
    wire [15:0] rd_mux = (ar_addr == ADDR_CTRL) ? ctrl
        : (ar_addr == ADDR_STATUS) ? status_word
        : (ar_addr == ADDR_COUNT) ? cnt_word
        : (ar_addr == ADDR_SOURCE) ? src_word
        : (ar_addr == ADDR_DEST) ? dst_word
        : (ar_addr == ADDR_TYPE) ? type_word
        : (ar_addr == ADDR_RXDATA) ? mem_q : 16'h0000;
    wire rd_mapped = (ar_addr == ADDR_CTRL) || (ar_addr == ADDR_STATUS)
        || (ar_addr == ADDR_COUNT) || (ar_addr == ADDR_SOURCE)
        || (ar_addr == ADDR_DEST) || (ar_addr == ADDR_TYPE)
        || (ar_addr == ADDR_TXDATA) || (ar_addr == ADDR_RXDATA);

    // Memory write only during commit of a checked block
    wire mem_we = (state == ST_COMMIT);
    wire [15:0] mem_wdata = blk[ci];

    tsv_mem tsv_mem_inst (
        .sys_clk(sys_clk),
        .we(mem_we),
        .waddr(dst_ptr),
        .wdata(mem_wdata),
        .raddr(rx_ptr),
        .rdata(mem_q)
    );

    // Completion and error flags; a set wins over a clear
    wire next_tx_done = tx_fin || (tx_done && ctrl[CTRL_TX_BIT]);
    wire next_rx_done = rx_fin || (rx_done && ctrl[CTRL_RX_BIT]);
    wire next_tx_err = tx_fin ? tx_fin_err : tx_err;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_done <= 1'b0;
            rx_done <= 1'b0;
            tx_err <= 1'b0;
        end else begin
            tx_done <= next_tx_done;
            rx_done <= next_rx_done;
            tx_err <= next_tx_err;
        end
    end

    // Software registers; descriptor frozen while a transfer runs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            cnt_word <= DESC_RESET;
            src_word <= DESC_RESET;
            dst_word <= DESC_RESET;
            type_word <= DESC_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= merge(ctrl, w_data, w_strb);
            end
            if (wr_desc_ok && aw_addr == ADDR_COUNT) begin
                cnt_word <= merge(cnt_word, w_data, w_strb);
            end
            if (wr_desc_ok && aw_addr == ADDR_SOURCE) begin
                src_word <= merge(src_word, w_data, w_strb);
            end
            if (wr_desc_ok && aw_addr == ADDR_DEST) begin
                dst_word <= merge(dst_word, w_data, w_strb);
            end
            if (wr_desc_ok && aw_addr == ADDR_TYPE) begin
                type_word <= merge(type_word, w_data, w_strb);
            end
        end
    end

    // Transfer sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            widx <= 2'h0;
            ci <= 2'h0;
            left <= 14'h0000;
            dst_ptr <= '0;
            rx_ptr <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    widx <= 2'h0;
                    ci <= 2'h0;
                    left <= cnt_bin;
                    dst_ptr <= dst_bin[MEM_AW-1:0];
                    rx_ptr <= dst_bin[MEM_AW-1:0];
                    if (tx_req && !desc_bad) begin
                        state <= ST_TX_DATA;
                    end else if (rx_req && !rx_fin) begin
                        state <= ST_RX_DATA;
                    end
                end
                ST_TX_DATA: begin
                    if (wr_push) begin
                        left <= left - 14'h0001;
                        widx <= widx + 2'h1;
                        if (blk_end) begin
                            widx <= 2'h0;
                            state <= blk_bad ? ST_IDLE : ST_COMMIT;
                        end
                    end
                end
                ST_COMMIT: begin
                    dst_ptr <= dst_ptr + MEM_AW'(1);
                    ci <= ci + 2'h1;
                    if (commit_end) begin
                        ci <= 2'h0;
                        state <= (left == 14'h0000) ? ST_IDLE : ST_TX_DATA;
                    end
                end
                ST_RX_DATA: begin
                    if (rd_pop) begin
                        left <= left - 14'h0001;
                        rx_ptr <= rx_ptr + MEM_AW'(1);
                        if (left == 14'h0001) begin
                            state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Block staging
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            blk[0] <= 16'h0000;
            blk[1] <= 16'h0000;
            blk[2] <= 16'h0000;
        end else if (wr_push) begin
            blk[widx] <= last_word;
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_taken) begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (w_taken) begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: answer two cycles after the address is taken
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            ar_addr <= 8'h00;
            rd_pend <= 1'b0;
        end else begin
            if (ar_taken) begin
                s_axi_arready <= 1'b0;
                ar_addr <= s_axi_araddr;
                rd_pend <= 1'b1;
            end
            if (rd_pend) begin
                rd_pend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, rd_mux};
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : tsv_transfer_status
`default_nettype wire

// ### tsv_transfer_status_props.sv
// Port checker for the transfer status block
`timescale 1ns/100ps
`default_nettype none
module tsv_transfer_status_props
    import tsv_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    wire logic rd_take = s_axi_arvalid && s_axi_arready;
    wire logic rd_mapped = s_axi_araddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_COUNT, ADDR_SOURCE,
        ADDR_DEST, ADDR_TYPE, ADDR_TXDATA, ADDR_RXDATA};

    sequence rd_answer;
        !s_axi_arready ##1 s_axi_rvalid;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence

    read_latency_a: assert property (rd_take |=> rd_answer)
        else $error("read answer not two cycles after address");
    unmapped_read_a: assert property (rd_take && !rd_mapped |=> ##1 s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not answered with slave error");
    mapped_read_a: assert property (rd_take && rd_mapped |=> ##1 s_axi_rresp == RESP_OKAY)
        else $error("mapped read not answered okay");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed before taken");
    write_resp_a: assert property (wr_take |=> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before taken");
    aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address slot still open after take");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
endmodule : tsv_transfer_status_props

bind tsv_transfer_status tsv_transfer_status_props tsv_transfer_status_props_inst (.sys_clk,
    .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ### tsv_host_model.sv
// Host controller model: register bus master and completion handshake
`timescale 1ns/100ps
`default_nettype none
module tsv_host_model
    import tsv_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Write channels
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // Released payload is inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~{16'h0000, d};
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata[15:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // Poll status until a flag reaches a level before touching control again
    task automatic await_flag(input int b, input logic lvl, output logic [15:0] st);
        logic [1:0] r;
        do rd(ADDR_STATUS, st, r); while (st[b] !== lvl);
    endtask : await_flag
endmodule : tsv_host_model
`default_nettype wire

// ### tsv_transfer_status_tb.sv
// Testbench for the transfer status block
`timescale 1ns/100ps
`default_nettype none
module tsv_transfer_status_tb
    import tsv_pkg::*;
;
    typedef struct packed {logic [15:0] cnt, src, dst; logic [2:0] dk; logic err;} tsv_row_t;
    localparam int NR = 17;
    logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] st, d;
    logic [15:0] dat [7][4];
    tsv_row_t rows [NR];
    int miscompares, num_checks;

    tsv_transfer_status tsv_transfer_status_inst (.sys_clk, .rst_n, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    tsv_host_model tsv_host_model_inst (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        // Data kinds: good position, bad digit, top digit 4, point 5, parameter cases
        dat = '{'{16'h9999, 16'h3999, 16'h8004, 16'h0000}, '{16'h12a4, 16'h0000, 16'h0000, 16'h0000},
            '{16'h0000, 16'h4000, 16'h0000, 16'h0000}, '{16'h0000, 16'h0000, 16'h0005, 16'h0000},
            '{16'h0000, 16'h9999, 16'h0003, 16'h0001}, '{16'h0000, 16'h99a9, 16'h0003, 16'h0001},
            '{16'h0000, 16'h9999, 16'h0003, 16'h0002}};
        rows = '{'{16'h0003, 16'h0000, 16'h0000, 3'd0, 1'b0}, '{16'h000a, 16'h0000, 16'h0000, 3'd0, 1'b1},
            '{16'h0003, 16'h00a0, 16'h0000, 3'd0, 1'b1}, '{16'h0003, 16'h0000, 16'h000b, 3'd0, 1'b1},
            '{16'h0003, 16'h6656, 16'h0000, 3'd0, 1'b1}, '{16'h0003, 16'h0000, 16'h1022, 3'd0, 1'b1},
            '{16'h0003, 16'h0000, 16'h1021, 3'd0, 1'b0}, '{16'h0002, 16'h0000, 16'h0010, 3'd4, 1'b1},
            '{16'h0004, 16'h0000, 16'h0000, 3'd0, 1'b1}, '{16'h0003, 16'h6654, 16'h0000, 3'd0, 1'b1},
            '{16'h0003, 16'h6653, 16'h0000, 3'd0, 1'b0}, '{16'h0003, 16'h0000, 16'h0000, 3'd1, 1'b1},
            '{16'h0003, 16'h0000, 16'h0000, 3'd2, 1'b1}, '{16'h0003, 16'h0000, 16'h0000, 3'd3, 1'b1},
            '{16'h0004, 16'h0000, 16'h0010, 3'd4, 1'b0}, '{16'h0004, 16'h0000, 16'h0010, 3'd5, 1'b1},
            '{16'h0004, 16'h0000, 16'h0010, 3'd6, 1'b1}};
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < NR; i++) begin
            tsv_host_model_inst.wr(ADDR_COUNT, rows[i].cnt, r);
            tsv_host_model_inst.wr(ADDR_SOURCE, rows[i].src, r);
            tsv_host_model_inst.wr(ADDR_DEST, rows[i].dst, r);
            tsv_host_model_inst.wr(ADDR_TYPE, {15'h0000, rows[i].dk >= 3'd4}, r);
            tsv_host_model_inst.wr(ADDR_CTRL, 16'h0001 << CTRL_TX_BIT, r);
            for (int k = 0; k < 4; k++) tsv_host_model_inst.wr(ADDR_TXDATA, dat[rows[i].dk][k], r);
            tsv_host_model_inst.await_flag(STAT_TX_DONE_BIT, 1'b1, st);
            tsv_host_model_inst.rd(ADDR_STATUS, st, r);
            check("tx_error", st[STAT_TX_ERR_BIT], rows[i].err);
            check("tx_done_busy", {st[STAT_TX_DONE_BIT], st[STAT_BUSY_BIT]}, 2'h2);
            tsv_host_model_inst.wr(ADDR_CTRL, 16'h0000, r);
            tsv_host_model_inst.await_flag(STAT_TX_DONE_BIT, 1'b0, st);
        end
        // Rejected blocks at word 0 must have left the last good block intact
        tsv_host_model_inst.wr(ADDR_COUNT, 16'h0003, r);
        tsv_host_model_inst.wr(ADDR_DEST, 16'h0000, r);
        tsv_host_model_inst.wr(ADDR_CTRL, 16'h0001 << CTRL_RX_BIT, r);
        for (int k = 0; k < 3; k++) begin
            tsv_host_model_inst.rd(ADDR_RXDATA, d, r);
            check("rx_word", d, dat[0][k]);
        end
        tsv_host_model_inst.await_flag(STAT_RX_DONE_BIT, 1'b1, st);
        tsv_host_model_inst.rd(ADDR_STATUS, st, r);
        check("rx_done_idle", {st[STAT_RX_DONE_BIT], st[STAT_BUSY_BIT]}, 2'h2);
        tsv_host_model_inst.wr(ADDR_CTRL, 16'h0000, r);
        tsv_host_model_inst.await_flag(STAT_RX_DONE_BIT, 1'b0, st);
        // Failed reception still completes
        tsv_host_model_inst.wr(ADDR_COUNT, 16'h0000, r);
        tsv_host_model_inst.wr(ADDR_CTRL, 16'h0001 << CTRL_RX_BIT, r);
        tsv_host_model_inst.await_flag(STAT_RX_DONE_BIT, 1'b1, st);
        tsv_host_model_inst.wr(ADDR_CTRL, 16'h0000, r);
        tsv_host_model_inst.await_flag(STAT_RX_DONE_BIT, 1'b0, st);
        tsv_host_model_inst.rd(8'h40, d, r);
        check("unmapped_rd", {r, d}, {RESP_SLVERR, 16'h0000});
        tsv_host_model_inst.wr(8'h40, 16'h1234, r);
        check("unmapped_wr", r, RESP_SLVERR);
        // Leave control and both completion flags set so reset has work to undo
        tsv_host_model_inst.wr(ADDR_CTRL, 16'hffff, r);
        // Second reset in mid-run
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        tsv_host_model_inst.rd(ADDR_CTRL, d, r);
        check("ctrl_reset", d, CTRL_RESET);
        tsv_host_model_inst.rd(ADDR_TYPE, d, r);
        check("type_reset", d, DESC_RESET);
        tsv_host_model_inst.wr(ADDR_STATUS, 16'hffff, r);
        check("status_wr_resp", r, RESP_SLVERR);
        tsv_host_model_inst.rd(ADDR_STATUS, d, r);
        check("status_ro", d, 16'h0000);
        final_report();
    end
endmodule : tsv_transfer_status_tb
`default_nettype wire
